// ===== shared/scss_pkg.sv
// Package with register map, field layout and timing constants of the clock selector
`default_nettype none
package scss_pkg;
  localparam logic [11:0] SCSS_OFF_SYS_CTRL = 12'h000;
  localparam logic [11:0] SCSS_OFF_FAST_CTRL = 12'h004;
  localparam logic [11:0] SCSS_OFF_XTAL_CTRL = 12'h008;
  localparam logic [11:0] SCSS_OFF_PIN_CTRL = 12'h00c;
  localparam logic [11:0] SCSS_OFF_STATUS = 12'h010;

  localparam int SCSS_SEL_POS = 5;
  localparam int SCSS_SLOW_SRC_POS = 2;
  localparam int SCSS_FAST_IDLE_POS = 1;
  localparam int SCSS_SLOW_IDLE_POS = 0;
  localparam int SCSS_FREQ_POS = 2;
  localparam int SCSS_STABLE_POS = 1;
  localparam int SCSS_ENABLE_POS = 0;
  localparam int SCSS_PIN_XTAL_POS = 0;

  localparam logic [2:0] SCSS_SEL_FAST = 3'h0;
  localparam logic [2:0] SCSS_SEL_SUB = 3'h7;
  localparam logic [2:0] SCSS_SEL_RST = 3'h0;
  localparam logic SCSS_SLOW_SRC_RST = 1'b0;
  localparam logic SCSS_FAST_EN_RST = 1'b1;
  localparam logic [1:0] SCSS_FREQ_RST = 2'h0;
  localparam logic [1:0] SCSS_FREQ_8A = 2'h0;
  localparam logic [1:0] SCSS_FREQ_12 = 2'h1;
  localparam logic [1:0] SCSS_FREQ_16 = 2'h2;
  localparam logic [1:0] SCSS_FREQ_8B = 2'h3;

  localparam int SCSS_DIV_W = 6;
  localparam int SCSS_CLK_PERIOD_NS = 4;
  localparam int SCSS_FAST_SETTLE_NS = 16000;
  localparam int SCSS_FAST_SETTLE_CYC =
    (SCSS_FAST_SETTLE_NS + SCSS_CLK_PERIOD_NS - 1) / SCSS_CLK_PERIOD_NS;
  localparam int SCSS_XTAL_STARTUP_US = 1000;
  localparam int SCSS_XTAL_STARTUP_CYC =
    (SCSS_XTAL_STARTUP_US * 1000 + SCSS_CLK_PERIOD_NS - 1) / SCSS_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SCSS_SW_IDLE = 2'b00,
    SCSS_SW_OLD = 2'b01,
    SCSS_SW_NEW = 2'b11
  } scss_sw_state_t;

  typedef struct packed {
    logic [2:0] sel;
    logic slow_src;
    logic fast_idle_en;
    logic slow_idle_en;
  } scss_sys_ctrl_t;
endpackage : scss_pkg
`default_nettype wire

// ===== rtl/scss_top.sv
// Clock source selector with APB registers, oscillator control and glitch-free mux
// How it works
// - Core clock comes from fast or sub clock per three-bit select field.
// - Fast clock divided by 2 to 64 offered as core clock choices.
// - Sub clock is slow crystal or slow RC per slow source select bit.
// - Fast RC frequency 8, 12 or 16 MHz set by the fast control register; the strap option only flags a mismatch.
// - Slow crystal starts on enable, usable only after start-up delay.
// - One fast and one slow oscillator always selected, never none.
// - Selection may change at run time without reset.
// - On sub clock, fast RC stops or runs per its enable bit.
// - Halt gates the core clock; timer clocks keep running.
// - Watchdog and time base get their own oscillator clocks.
// - Pin-share bit or a running crystal hands crystal pins to crystal, else general I/O.
// - Select codes 0..6 are fast divided by 1..64, code 7 sub.
// - Slow source bit 0 is slow RC, 1 crystal; resets to 0.
// - Frequency field 0 and 3 mean 8 MHz, 1 12 MHz, 2 16 MHz.
// - New fast RC frequency used only once stable flag is 1.
`timescale 1ns/1ns
`default_nettype none
module scss_top
  import scss_pkg::*;
#(
  parameter int unsigned XTAL_STARTUP_CYCLES = SCSS_XTAL_STARTUP_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic fast_rc_clk,
  input wire logic slow_rc_clk,
  input wire logic slow_crystal_clk,
  input wire logic [1:0] fast_rc_option,
  input wire logic cpu_halt,
  output logic core_system_clock,
  output logic fast_clock,
  output logic [5:0] fast_div_clock,
  output logic sub_clock,
  output logic wdt_clock,
  output logic time_base_clock,
  output logic fast_rc_enable,
  output logic [1:0] fast_rc_freq_select,
  output logic [1:0] fast_rc_freq_applied,
  output logic slow_crystal_enable,
  output logic fast_idle_enable,
  output logic slow_idle_enable,
  input wire logic crystal_in_pin_i,
  output logic crystal_in_pin_o,
  output logic crystal_in_pin_oe,
  input wire logic crystal_out_pin_i,
  output logic crystal_out_pin_o,
  output logic crystal_out_pin_oe,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic [1:0] gpio_in,
  output logic crystal_pins_owned
);

  function automatic logic scss_src(input logic [3:0] key, input logic fast_c,
                                    input logic [5:0] cnt, input logic rc_c,
                                    input logic xt_c);
    logic [2:0] sel;
    logic res;
    sel = key[3:1];
    res = 1'b0;
    case (sel)
      SCSS_SEL_FAST: res = fast_c;
      SCSS_SEL_SUB: res = key[0] ? xt_c : rc_c;
      default: res = cnt[3'(sel - 3'h1)];
    endcase
    return res;
  endfunction : scss_src

  function automatic logic [4:0] scss_mhz(input logic [1:0] code);
    logic [4:0] mhz;
    mhz = 5'h08;
    case (code)
      SCSS_FREQ_12: mhz = 5'h0c;
      SCSS_FREQ_16: mhz = 5'h10;
      default: mhz = 5'h08;
    endcase
    return mhz;
  endfunction : scss_mhz

  // Oscillator inputs are asynchronous, two stages then an edge stage
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic fast_prev_ff;
  scss_sys_ctrl_t ctrl_ff;
  logic fast_en_ff;
  logic [1:0] freq_ff;
  logic [1:0] applied_ff;
  logic fast_stable_ff;
  logic [11:0] fast_cnt_ff;
  logic fast_on_prev_ff;
  logic xtal_en_ff;
  logic xtal_stable_ff;
  logic [19:0] xtal_cnt_ff;
  logic pin_xtal_ff;
  logic [1:0] cfg_ff;
  logic cfg_done_ff;
  logic [5:0] div_ff;
  logic [3:0] cur_key_ff;
  scss_sw_state_t state_ff;
  scss_sw_state_t nxt_state;
  logic core_clk_ff;
  logic run_ff;
  logic [31:0] prdata_ff;

  wire logic fast_s = sync2_ff[0];
  wire logic rc_s = sync2_ff[1];
  wire logic xt_s = sync2_ff[2];
  wire logic wr_acc = psel & penable & pwrite;
  wire logic rd_setup = psel & ~penable & ~pwrite;
  wire logic hit_sys = (paddr == SCSS_OFF_SYS_CTRL);
  wire logic hit_fast = (paddr == SCSS_OFF_FAST_CTRL);
  wire logic hit_xtal = (paddr == SCSS_OFF_XTAL_CTRL);
  wire logic hit_pin = (paddr == SCSS_OFF_PIN_CTRL);
  wire logic hit_stat = (paddr == SCSS_OFF_STATUS);
  wire logic mapped = hit_sys | hit_fast | hit_xtal | hit_pin | hit_stat;
  wire logic wr_sys = wr_acc & hit_sys;
  wire logic wr_fast = wr_acc & hit_fast;
  wire logic wr_xtal = wr_acc & hit_xtal;
  wire logic wr_pin = wr_acc & hit_pin;

  wire logic cur_on_sub = (cur_key_ff[3:1] == SCSS_SEL_SUB);
  wire logic cur_on_xtal = cur_on_sub & cur_key_ff[0];
  // Fast RC held on while any fast-derived core clock is selected or in flight
  wire logic fast_on = fast_en_ff | ~cur_on_sub | (ctrl_ff.sel != SCSS_SEL_SUB);
  wire logic xtal_on = xtal_en_ff | cur_on_xtal;
  // Crystal not yet started falls back to the slow RC, so sub clock never starves
  wire logic sub_src_eff = ctrl_ff.slow_src & xtal_stable_ff;
  wire logic fast_g = fast_s & fast_stable_ff;
  wire logic fast_rise = fast_s & ~fast_prev_ff;
  wire logic sub_w = sub_src_eff ? xt_s : rc_s;
  wire logic [3:0] tgt_key = {ctrl_ff.sel, sub_src_eff};
  wire logic src_cur = scss_src(cur_key_ff, fast_g, div_ff, rc_s, xt_s);
  wire logic src_tgt = scss_src(tgt_key, fast_g, div_ff, rc_s, xt_s);
  wire logic fast_restart = (fast_on & ~fast_on_prev_ff) |
                            (wr_fast & (pwdata[SCSS_FREQ_POS+:2] != freq_ff));
  wire logic cfg_mismatch = (scss_mhz(freq_ff) != scss_mhz(cfg_ff));
  wire logic pins_xtal = pin_xtal_ff | xtal_on;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      fast_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {slow_crystal_clk, slow_rc_clk, fast_rc_clk};
      sync2_ff <= sync1_ff;
      fast_prev_ff <= fast_s;
    end
  end

  // Strap is caught after reset release, once
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_ff <= SCSS_FREQ_RST;
      cfg_done_ff <= 1'b0;
    end else if (!cfg_done_ff) begin
      cfg_ff <= fast_rc_option;
      cfg_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_ff <= '{sel: SCSS_SEL_RST, slow_src: SCSS_SLOW_SRC_RST,
                   fast_idle_en: 1'b0, slow_idle_en: 1'b0};
      fast_en_ff <= SCSS_FAST_EN_RST;
      freq_ff <= SCSS_FREQ_RST;
      xtal_en_ff <= 1'b0;
      pin_xtal_ff <= 1'b0;
    end else begin
      if (wr_sys) begin
        ctrl_ff <= scss_sys_ctrl_t'({pwdata[SCSS_SEL_POS+:3], pwdata[SCSS_SLOW_SRC_POS],
                                     pwdata[SCSS_FAST_IDLE_POS], pwdata[SCSS_SLOW_IDLE_POS]});
      end
      if (wr_fast) begin
        fast_en_ff <= pwdata[SCSS_ENABLE_POS];
        freq_ff <= pwdata[SCSS_FREQ_POS+:2];
      end
      if (wr_xtal) begin
        xtal_en_ff <= pwdata[SCSS_ENABLE_POS];
      end
      if (wr_pin) begin
        pin_xtal_ff <= pwdata[SCSS_PIN_XTAL_POS];
      end
    end
  end

  // Fast RC settle timer restarts on start-up and on every frequency change
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fast_on_prev_ff <= 1'b0;
      fast_cnt_ff <= 12'h000;
      fast_stable_ff <= 1'b0;
      applied_ff <= SCSS_FREQ_RST;
    end else begin
      fast_on_prev_ff <= fast_on;
      if (!fast_on || fast_restart) begin
        fast_cnt_ff <= 12'h000;
        fast_stable_ff <= 1'b0;
      end else if (!fast_stable_ff) begin
        if (fast_cnt_ff == 12'(SCSS_FAST_SETTLE_CYC - 1)) begin
          fast_stable_ff <= 1'b1;
          applied_ff <= freq_ff;
        end else begin
          fast_cnt_ff <= fast_cnt_ff + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xtal_cnt_ff <= 20'h00000;
      xtal_stable_ff <= 1'b0;
    end else if (!xtal_on) begin
      xtal_cnt_ff <= 20'h00000;
      xtal_stable_ff <= 1'b0;
    end else if (!xtal_stable_ff) begin
      if (xtal_cnt_ff == 20'(XTAL_STARTUP_CYCLES - 1)) begin
        xtal_stable_ff <= 1'b1;
      end else begin
        xtal_cnt_ff <= xtal_cnt_ff + 20'h00001;
      end
    end
  end

  // Ripple-free divider: all taps move on the same sampled fast edge
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_ff <= 6'h00;
    end else if (fast_rise && fast_stable_ff) begin
      div_ff <= div_ff + 6'h01;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SCSS_SW_IDLE: if (tgt_key != cur_key_ff) nxt_state = SCSS_SW_OLD;
      SCSS_SW_OLD: if (!src_cur) nxt_state = SCSS_SW_NEW;
      SCSS_SW_NEW: if (!src_tgt) nxt_state = SCSS_SW_IDLE;
      default: nxt_state = SCSS_SW_IDLE;
    endcase
  end

  // Output is frozen low from the old clock's low phase to the new clock's low phase
  wire logic nxt_core_raw = (state_ff == SCSS_SW_OLD) ? (src_cur & nxt_state == SCSS_SW_OLD) :
                            (state_ff == SCSS_SW_NEW) ? 1'b0 : src_cur;
  wire logic nxt_run = core_clk_ff ? run_ff : ~cpu_halt;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= SCSS_SW_IDLE;
      cur_key_ff <= {SCSS_SEL_RST, SCSS_SLOW_SRC_RST};
      core_clk_ff <= 1'b0;
      run_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == SCSS_SW_NEW && !src_tgt) begin
        cur_key_ff <= tgt_key;
      end
      run_ff <= nxt_run;
      core_clk_ff <= nxt_core_raw & nxt_run;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= 32'h0000_0000;
      if (hit_sys) prdata_ff[7:0] <= {ctrl_ff.sel, 2'b00, ctrl_ff.slow_src,
                                      ctrl_ff.fast_idle_en, ctrl_ff.slow_idle_en};
      if (hit_fast) prdata_ff[3:0] <= {freq_ff, fast_stable_ff, fast_en_ff};
      if (hit_xtal) prdata_ff[1:0] <= {xtal_stable_ff, xtal_en_ff};
      if (hit_pin) prdata_ff[0] <= pin_xtal_ff;
      if (hit_stat) prdata_ff[7:0] <= {cfg_mismatch, state_ff != SCSS_SW_IDLE, 2'b00, cur_key_ff};
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;
  assign core_system_clock = core_clk_ff;
  assign fast_clock = fast_g;
  assign fast_div_clock = div_ff;
  assign sub_clock = sub_w;
  assign wdt_clock = rc_s;
  assign time_base_clock = sub_w;
  assign fast_rc_enable = fast_on;
  assign fast_rc_freq_select = freq_ff;
  assign fast_rc_freq_applied = applied_ff;
  assign slow_crystal_enable = xtal_on;
  assign fast_idle_enable = ctrl_ff.fast_idle_en;
  assign slow_idle_enable = ctrl_ff.slow_idle_en;
  // Crystal owns the pins as analog nodes, so digital drivers are released
  assign crystal_in_pin_o = gpio_out[0];
  assign crystal_out_pin_o = gpio_out[1];
  assign crystal_in_pin_oe = gpio_oe[0] & ~pins_xtal;
  assign crystal_out_pin_oe = gpio_oe[1] & ~pins_xtal;
  assign gpio_in = pins_xtal ? 2'h0 : {crystal_out_pin_i, crystal_in_pin_i};
  assign crystal_pins_owned = pins_xtal;

  AST_SWITCH_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $changed(cur_key_ff) |-> !core_clk_ff && !$past(core_clk_ff))
    else $error("core clock switched while high");
  AST_SWITCH_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_ff == SCSS_SW_IDLE && tgt_key != cur_key_ff) |=> state_ff == SCSS_SW_OLD)
    else $error("selection change not started");
  AST_FAST_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cur_on_sub |-> fast_rc_enable)
    else $error("fast oscillator off while feeding core clock");
  AST_XTAL_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cur_on_xtal |-> slow_crystal_enable)
    else $error("crystal off while feeding sub clock");
  AST_FAST_GATED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fast_stable_ff |-> !fast_clock)
    else $error("unstable fast clock used");
  // Divider may still step on the edge that clears the stable flag
  AST_DIV_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$past(fast_stable_ff) |-> $stable(div_ff))
    else $error("divider ran on unstable fast clock");
  AST_XTAL_DELAY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(xtal_stable_ff) |-> $past(xtal_cnt_ff) == 20'(XTAL_STARTUP_CYCLES - 1))
    else $error("crystal usable before start-up delay");
  AST_HALT_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cpu_halt && !core_clk_ff) |=> !core_clk_ff && !run_ff)
    else $error("core clock not gated in halt");
  AST_SUB_SRC: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cur_on_xtal && state_ff == SCSS_SW_IDLE && !cpu_halt) |=> core_system_clock == $past(xt_s))
    else $error("sub clock not from crystal");
  AST_PINS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    slow_crystal_enable |-> !crystal_in_pin_oe && !crystal_out_pin_oe)
    else $error("crystal pins driven while crystal in use");
  AST_SLOW_RST: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> !ctrl_ff.slow_src && ctrl_ff.sel == SCSS_SEL_FAST)
    else $error("select fields wrong after reset");

endmodule : scss_top
`default_nettype wire

// ===== bench/test_system_clock_source_select.sv
// Self-checking testbench for the clock source selector
`timescale 1ns/1ns
`default_nettype none
module test_system_clock_source_select;
  import scss_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic fast_rc_clk = 1'b0;
  logic slow_rc_clk = 1'b0;
  logic slow_crystal_clk = 1'b0;
  logic [1:0] fast_rc_option = 2'h2;
  logic cpu_halt = 1'b0;
  logic core_system_clock, fast_clock, sub_clock, wdt_clock, time_base_clock;
  logic [5:0] fast_div_clock;
  logic fast_rc_enable, slow_crystal_enable, fast_idle_enable, slow_idle_enable;
  logic [1:0] fast_rc_freq_select, fast_rc_freq_applied, gpio_in;
  logic crystal_in_pin_i = 1'b1;
  logic crystal_out_pin_i = 1'b0;
  logic crystal_in_pin_o, crystal_in_pin_oe, crystal_out_pin_o, crystal_out_pin_oe;
  logic crystal_pins_owned;
  logic [1:0] gpio_out = 2'h2;
  logic [1:0] gpio_oe = 2'h3;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  int n;

  scss_top #(.XTAL_STARTUP_CYCLES(20)) u_scss_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fast_rc_clk(fast_rc_clk), .slow_rc_clk(slow_rc_clk), .slow_crystal_clk(slow_crystal_clk),
    .fast_rc_option(fast_rc_option), .cpu_halt(cpu_halt),
    .core_system_clock(core_system_clock), .fast_clock(fast_clock),
    .fast_div_clock(fast_div_clock), .sub_clock(sub_clock), .wdt_clock(wdt_clock),
    .time_base_clock(time_base_clock), .fast_rc_enable(fast_rc_enable),
    .fast_rc_freq_select(fast_rc_freq_select), .fast_rc_freq_applied(fast_rc_freq_applied),
    .slow_crystal_enable(slow_crystal_enable), .fast_idle_enable(fast_idle_enable),
    .slow_idle_enable(slow_idle_enable), .crystal_in_pin_i(crystal_in_pin_i),
    .crystal_in_pin_o(crystal_in_pin_o), .crystal_in_pin_oe(crystal_in_pin_oe),
    .crystal_out_pin_i(crystal_out_pin_i), .crystal_out_pin_o(crystal_out_pin_o),
    .crystal_out_pin_oe(crystal_out_pin_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in(gpio_in), .crystal_pins_owned(crystal_pins_owned));

  always #2 sys_clk = ~sys_clk;

  // Oscillators derived from sys_clk, so expected edge counts are exact
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 0) fast_rc_clk <= ~fast_rc_clk;
    if (cyc % 16 == 0) slow_rc_clk <= ~slow_rc_clk;
    if (cyc % 20 == 0) slow_crystal_clk <= ~slow_crystal_clk;
    if (cyc == 60000) begin
      bad_count++;
      $display("Error timeout: expected end before 60000 cycles, seen %0d", cyc);
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Edge counts may slip by one at window borders
  task automatic near(input string what, input int exp, input int got);
    num_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      bad_count++;
      $display("Error %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : near

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic poll(input logic [11:0] a, input int b, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === v) break;
    end
    chk("polled bit", {31'h0, v}, {31'h0, rd[b]});
  endtask : poll

  task automatic count_edges(input int sel, input int len, output int cnt);
    logic prev, cur;
    cnt = 0;
    prev = 1'b1;
    repeat (len) begin
      @(posedge sys_clk);
      cur = (sel == 0) ? core_system_clock : (sel == 1) ? wdt_clock :
            (sel == 2) ? time_base_clock : fast_div_clock[5];
      if (cur === 1'b1 && prev !== 1'b1) cnt++;
      prev = cur;
    end
  endtask : count_edges

  task automatic t_reset;
    apb(1'b0, SCSS_OFF_SYS_CTRL, 32'h0);
    chk("sys ctrl reset", 32'h0, rd);
    apb(1'b0, SCSS_OFF_FAST_CTRL, 32'h0);
    chk("fast ctrl enable and freq", 32'h1, {rd[31:4], rd[3:2], 1'b0, rd[0]});
    apb(1'b0, SCSS_OFF_XTAL_CTRL, 32'h0);
    chk("crystal enable reset", 32'h0, {31'h0, rd[0]});
    chk("fast osc running", 32'h1, {31'h0, fast_rc_enable});
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pins;
    chk("pin enables", 32'h3, {30'h0, crystal_out_pin_oe, crystal_in_pin_oe});
    chk("pin outputs", 32'h2, {30'h0, crystal_out_pin_o, crystal_in_pin_o});
    chk("gpio inputs", 32'h1, {30'h0, gpio_in});
    apb(1'b1, SCSS_OFF_PIN_CTRL, 32'h1);
    chk("pins owned", 32'h1, {31'h0, crystal_pins_owned});
    chk("pin enables owned", 32'h0, {30'h0, crystal_out_pin_oe, crystal_in_pin_oe});
    chk("gpio inputs owned", 32'h0, {30'h0, gpio_in});
    apb(1'b1, SCSS_OFF_PIN_CTRL, 32'h0);
    chk("pins released", 32'h0, {31'h0, crystal_pins_owned});
    $display("test pins done");
  endtask : t_pins

  task automatic t_fast;
    logic [1:0] seq [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    poll(SCSS_OFF_FAST_CTRL, SCSS_STABLE_POS, 1'b1, 2000);
    chk("applied at start", {30'h0, SCSS_FREQ_8A}, {30'h0, fast_rc_freq_applied});
    foreach (seq[i]) begin
      apb(1'b1, SCSS_OFF_FAST_CTRL, {28'h0, seq[i], 2'h1});
      chk("freq select", {30'h0, seq[i]}, {30'h0, fast_rc_freq_select});
      chk("applied held", {30'h0, seq[(i + 3) % 4]}, {30'h0, fast_rc_freq_applied});
      poll(SCSS_OFF_FAST_CTRL, SCSS_STABLE_POS, 1'b1, 2000);
      chk("applied freq", {30'h0, seq[i]}, {30'h0, fast_rc_freq_applied});
      apb(1'b0, SCSS_OFF_STATUS, 32'h0);
      chk("strap mismatch", {31'h0, seq[i] != 2'h2}, {31'h0, rd[7]});
    end
    $display("test fast rc done");
  endtask : t_fast

  task automatic t_sel;
    for (int s = 0; s < 7; s++) begin
      apb(1'b1, SCSS_OFF_SYS_CTRL, 32'(s) << SCSS_SEL_POS);
      poll(SCSS_OFF_STATUS, 6, 1'b0, 100);
      chk("current select", 32'(s), {29'h0, rd[3:1]});
      count_edges(0, 1024, n);
      near("divided core edges", 1024 / (4 << s), n);
    end
    apb(1'b1, SCSS_OFF_SYS_CTRL, 32'he0);
    poll(SCSS_OFF_STATUS, 6, 1'b0, 100);
    count_edges(0, 1024, n);
    near("slow rc core edges", 32, n);
    $display("test select done");
  endtask : t_sel

  task automatic t_sub;
    apb(1'b1, SCSS_OFF_XTAL_CTRL, 32'h1);
    chk("crystal running", 32'h1, {31'h0, slow_crystal_enable});
    apb(1'b0, SCSS_OFF_XTAL_CTRL, 32'h0);
    chk("crystal not yet stable", 32'h0, {31'h0, rd[1]});
    poll(SCSS_OFF_XTAL_CTRL, 1, 1'b1, 50);
    apb(1'b1, SCSS_OFF_SYS_CTRL, 32'he4);
    poll(SCSS_OFF_STATUS, 6, 1'b0, 100);
    chk("sub source crystal", 32'h1, {31'h0, rd[0]});
    count_edges(0, 1024, n);
    near("crystal core edges", 25, n);
    count_edges(2, 1024, n);
    near("time base edges", 25, n);
    chk("pins owned by crystal", 32'h1, {31'h0, crystal_pins_owned});
    apb(1'b1, SCSS_OFF_FAST_CTRL, 32'h8);
    chk("fast osc stopped", 32'h0, {31'h0, fast_rc_enable});
    apb(1'b1, SCSS_OFF_FAST_CTRL, 32'h9);
    chk("fast osc restarted", 32'h1, {31'h0, fast_rc_enable});
    apb(1'b1, SCSS_OFF_SYS_CTRL, 32'h0);
    poll(SCSS_OFF_STATUS, 6, 1'b0, 2000);
    poll(SCSS_OFF_FAST_CTRL, SCSS_STABLE_POS, 1'b1, 2000);
    $display("test sub clock done");
  endtask : t_sub

  task automatic t_halt;
    cpu_halt <= 1'b1;
    repeat (16) @(posedge sys_clk);
    count_edges(0, 256, n);
    near("halted core edges", 0, n);
    count_edges(1, 256, n);
    near("watchdog edges", 8, n);
    cpu_halt <= 1'b0;
    repeat (16) @(posedge sys_clk);
    count_edges(0, 256, n);
    near("resumed core edges", 64, n);
    count_edges(3, 1024, n);
    near("fast div64 edges", 4, n);
    apb(1'b1, SCSS_OFF_SYS_CTRL, 32'h3);
    chk("idle enables", 32'h3, {30'h0, fast_idle_enable, slow_idle_enable});
    apb(1'b0, SCSS_OFF_SYS_CTRL, 32'h0);
    chk("idle enables read", 32'h3, rd);
    $display("test halt done");
  endtask : t_halt

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_pins();
    t_fast();
    t_sel();
    t_sub();
    t_halt();
    end_sim();
  end
endmodule : test_system_clock_source_select
`default_nettype wire
